/* tmr_compare8.sv */
// 8-bit timer/counter with one compare unit and its register port.
// Assumes one 50 MHz clock, synchronous reset and a single-cycle register master.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module tmr_compare8 (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`TMR_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [7:0]             regRdata,
  output logic                        compareOutputPin,
  output logic                        compareOutputOverride,
  output logic                        overflowFlag,
  output logic                        compareFlag
);
  // ****************************************************************
  // State.
  // ****************************************************************
  logic [6:0] ctrl_q, ctrl_d;          // Force bit is never stored.
  logic [7:0] count_q, count_d;
  logic [7:0] cmp_q, cmp_d;            // Active compare value.
  logic [7:0] cmpBuf_q, cmpBuf_d;      // Value software wrote.
  logic       down_q, down_d;
  logic       block_q, block_d;
  logic       pin_q, pin_d;
  logic       ovf_q, ovf_d;
  logic       cmpf_q, cmpf_d;
  logic [7:0] rdata_q, rdata_d;
  logic       tick;

  tmr_pkg::tmr_wave_e    wave;
  tmr_pkg::tmr_outmode_e outMode;
  tmr_pkg::tmr_wave_e    frcWave;      // Wave field written with the strobe.
  tmr_pkg::tmr_outmode_e frcMode;      // Output field written with the strobe.
  logic       frcPwm, upNow;
  logic       isPwm, atTop, match, forceHit, wrCtrl, wrCount, wrCmp;
  logic [7:0] topVal;

  tmr_prescaler #(.PRE_W(`TMR_PRE_W)) u_pre (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clockSel  (ctrl_q[`TMR_CS_HI:`TMR_CS_LO]),
    .timerTick (tick)
  );

  // ****************************************************************
  // Decode of the control fields.
  // ****************************************************************
  // Wave bits are split across the register, so reassemble them.
  assign wave    = tmr_pkg::tmr_wave_e'({ctrl_q[`TMR_BIT_WAVE1], ctrl_q[`TMR_BIT_WAVE0]});
  assign outMode = tmr_pkg::tmr_outmode_e'({ctrl_q[`TMR_BIT_MODE1], ctrl_q[`TMR_BIT_MODE0]});
  assign isPwm   = (wave == tmr_pkg::TMR_WAVE_PHASE) || (wave == tmr_pkg::TMR_WAVE_FAST);
  assign topVal  = (wave == tmr_pkg::TMR_WAVE_CLEAR) ? cmp_q : `TMR_MAX;
  assign wrCtrl  = regWrite && (regAddr == `TMR_OFS_CTRL);
  assign wrCount = regWrite && (regAddr == `TMR_OFS_COUNT);
  assign wrCmp   = regWrite && (regAddr == `TMR_OFS_CMP);
  // The strobe travels with the new fields, so those decide whether and how it acts.
  assign frcWave  = tmr_pkg::tmr_wave_e'({regWdata[`TMR_BIT_WAVE1], regWdata[`TMR_BIT_WAVE0]});
  assign frcMode  = tmr_pkg::tmr_outmode_e'({regWdata[`TMR_BIT_MODE1], regWdata[`TMR_BIT_MODE0]});
  assign frcPwm   = (frcWave == tmr_pkg::TMR_WAVE_PHASE) || (frcWave == tmr_pkg::TMR_WAVE_FAST);
  assign forceHit = wrCtrl && regWdata[`TMR_BIT_FORCE] && !frcPwm;
  // At BOTTOM the count turns upward, so a match there is an up-counting one.
  assign upNow    = !down_q || (count_q == `TMR_BOTTOM);
  // Match is evaluated on the timer tick and suppressed after a counter write.
  assign match   = tick && (count_q == cmp_q) && !block_q;
  assign atTop   = (count_q == topVal);

  // ****************************************************************
  // Counter, compare buffer and flags.
  // ****************************************************************
  always_comb begin
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    cmp_d    = cmp_q;
    cmpBuf_d = cmpBuf_q;
    down_d   = down_q;
    block_d  = block_q;
    ovf_d    = ovf_q;
    cmpf_d   = cmpf_q;
    if (tick) begin
      block_d = 1'b0;
      if (match) begin
        cmpf_d = 1'b1;
      end
      unique case (wave)
        tmr_pkg::TMR_WAVE_PHASE: begin
          // Direction turns at MAX so MAX is held for one tick only.
          if (!down_q && count_q == `TMR_MAX) begin
            down_d  = 1'b1;
            count_d = count_q - 8'h01;
            cmp_d   = cmpBuf_q;
          end else if (down_q && count_q == `TMR_BOTTOM) begin
            down_d  = 1'b0;
            count_d = count_q + 8'h01;
            ovf_d   = 1'b1;
          end else begin
            count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
          end
        end
        tmr_pkg::TMR_WAVE_CLEAR: begin
          down_d  = 1'b0;
          // Forced matches never reach this clear path.
          count_d = atTop ? `TMR_BOTTOM : count_q + 8'h01;
          if (count_q == `TMR_MAX) begin
            ovf_d = 1'b1;
          end
        end
        default: begin
          down_d  = 1'b0;
          count_d = count_q + 8'h01;
          if (count_q == `TMR_MAX) begin
            ovf_d = 1'b1;
            if (wave == tmr_pkg::TMR_WAVE_FAST) begin
              cmp_d = cmpBuf_q;
            end
          end
        end
      endcase
    end
    if (!isPwm) begin
      cmp_d = cmpBuf_d;
    end
    if (wrCtrl) begin
      ctrl_d = regWdata[6:0];
    end
    if (wrCount) begin
      count_d = regWdata;
      block_d = 1'b1;
    end
    if (wrCmp) begin
      cmpBuf_d = regWdata;
      if (!isPwm) begin
        cmp_d = regWdata;
      end
    end
    // Status write clears flags with ones, but an event that sets a clear flag wins.
    if (regWrite && regAddr == `TMR_OFS_STAT) begin
      if (regWdata[`TMR_STAT_OVF] && !(ovf_d && !ovf_q)) begin
        ovf_d = 1'b0;
      end
      if (regWdata[`TMR_STAT_CMP] && !(cmpf_d && !cmpf_q)) begin
        cmpf_d = 1'b0;
      end
    end
  end

  // ****************************************************************
  // Waveform unit.
  // ****************************************************************
  // A forced match uses the non-PWM table and touches no flag.
  always_comb begin
    pin_d = pin_q;
    if (forceHit) begin
      unique case (frcMode)
        tmr_pkg::TMR_OUT_TOGGLE: pin_d = !pin_q;
        tmr_pkg::TMR_OUT_CLEAR:  pin_d = 1'b0;
        tmr_pkg::TMR_OUT_SET:    pin_d = 1'b1;
        default:                 pin_d = pin_q;
      endcase
    end else if (tick) begin
      unique case (wave)
        tmr_pkg::TMR_WAVE_FAST: begin
          if (outMode[1]) begin
            // Match is ignored at top; the top action still occurs.
            if (count_q == `TMR_MAX) begin
              pin_d = !outMode[0];
            end else if (match) begin
              pin_d = outMode[0];
            end
          end else if (outMode == tmr_pkg::TMR_OUT_TOGGLE && match) begin
            pin_d = !pin_q;
          end
        end
        tmr_pkg::TMR_WAVE_PHASE: begin
          if (outMode[1]) begin
            if (cmp_q == `TMR_MAX && count_q == `TMR_MAX) begin
              pin_d = !outMode[0];
            end else if (match) begin
              pin_d = upNow ? outMode[0] : !outMode[0];
            end
          end
        end
        default: begin
          if (match) begin
            unique case (outMode)
              tmr_pkg::TMR_OUT_TOGGLE: pin_d = !pin_q;
              tmr_pkg::TMR_OUT_CLEAR:  pin_d = 1'b0;
              tmr_pkg::TMR_OUT_SET:    pin_d = 1'b1;
              default:                 pin_d = pin_q;
            endcase
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Register read path.
  // ****************************************************************
  always_comb begin
    rdata_d = `TMR_ZERO8;
    if (regRead) begin
      unique case (regAddr)
        `TMR_OFS_CTRL:  rdata_d = {1'b0, ctrl_q};
        `TMR_OFS_COUNT: rdata_d = count_q;
        `TMR_OFS_CMP:   rdata_d = cmpBuf_q;
        default:        rdata_d = {6'h00, cmpf_q, ovf_q};
      endcase
    end
  end

  // Register everything; reset leaves the timer stopped and disconnected.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q   <= 7'h00;
      count_q  <= `TMR_ZERO8;
      cmp_q    <= `TMR_ZERO8;
      cmpBuf_q <= `TMR_ZERO8;
      down_q   <= 1'b0;
      block_q  <= 1'b0;
      pin_q    <= 1'b0;
      ovf_q    <= 1'b0;
      cmpf_q   <= 1'b0;
      rdata_q  <= `TMR_ZERO8;
    end else begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      cmp_q    <= cmp_d;
      cmpBuf_q <= cmpBuf_d;
      down_q   <= down_d;
      block_q  <= block_d;
      pin_q    <= pin_d;
      ovf_q    <= ovf_d;
      cmpf_q   <= cmpf_d;
      rdata_q  <= rdata_d;
    end
  end

  assign regRdata              = rdata_q;
  assign compareOutputPin      = pin_q;
  assign compareOutputOverride = |ctrl_q[`TMR_BIT_MODE1:`TMR_BIT_MODE0];
  assign overflowFlag          = ovf_q;
  assign compareFlag           = cmpf_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence forceInPwm;
    wrCtrl && regWdata[`TMR_BIT_FORCE] && frcPwm && !tick;
  endsequence

  force_pwm_ignored_a: assert property (forceInPwm |=> $stable(pin_q))
    else $error("force strobe changed pin in PWM mode");
  force_toggle_a: assert property (forceHit && frcMode == tmr_pkg::TMR_OUT_TOGGLE
      |=> pin_q != $past(pin_q))
    else $error("forced toggle did not toggle");
  force_no_flag_a: assert property (forceHit && !tick && !cmpf_q |=> !cmpf_q)
    else $error("forced match set compare flag");
  force_reads_zero_a: assert property (regRead && regAddr == `TMR_OFS_CTRL
      |=> !regRdata[`TMR_BIT_FORCE])
    else $error("force bit read as one");
  stopped_count_a: assert property (ctrl_q[2:0] == 3'h0 && !wrCount
      |=> $stable(count_q))
    else $error("counter moved while stopped");
  override_pin_a: assert property (wrCtrl
      |=> compareOutputOverride == (|$past(regWdata[`TMR_BIT_MODE1:`TMR_BIT_MODE0])))
    else $error("override mismatch");
  count_write_a: assert property (wrCount |=> count_q == $past(regWdata))
    else $error("counter write lost");
  count_block_a: assert property (wrCount |=> !match)
    else $error("match not blocked after counter write");
  wrap_ovf_a: assert property (tick && wave == tmr_pkg::TMR_WAVE_NORMAL
      && count_q == `TMR_MAX && !wrCount |=> ovf_q && count_q == `TMR_BOTTOM)
    else $error("overflow missing on wrap");
  phase_turn_a: assert property (tick && wave == tmr_pkg::TMR_WAVE_PHASE && !down_q
      && count_q == `TMR_MAX && !wrCount && !wrCtrl |=> down_q && count_q == 8'hFE)
    else $error("phase mode did not turn at MAX");
endmodule

/* tmr_defines.svh */
// Constants for the 8-bit timer with one compare unit: register offsets, field
// positions, reset values and prescaler tap points.
// Assumes inclusion by bare name from the timer design files.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define TMR_ADDR_W       2
`define TMR_OFS_CTRL     2'h0
`define TMR_OFS_COUNT    2'h1
`define TMR_OFS_CMP      2'h2
`define TMR_OFS_STAT     2'h3

// ****************************************************************
// Control register fields and values.
// ****************************************************************
`define TMR_CTRL_RESET   8'h00
`define TMR_BIT_FORCE    7
`define TMR_BIT_WAVE0    6
`define TMR_BIT_MODE1    5
`define TMR_BIT_MODE0    4
`define TMR_BIT_WAVE1    3
`define TMR_CS_HI        2
`define TMR_CS_LO        0
`define TMR_STAT_OVF     0
`define TMR_STAT_CMP     1
`define TMR_MAX          8'hFF
`define TMR_BOTTOM       8'h00
`define TMR_ZERO8        8'h00

// ****************************************************************
// Prescaler tap points, as bit index of a free-running divider.
// ****************************************************************
`define TMR_PRE_W        10
`define TMR_DIV8_TAP     2
`define TMR_DIV32_TAP    4
`define TMR_DIV64_TAP    5
`define TMR_DIV128_TAP   6
`define TMR_DIV256_TAP   7
`define TMR_DIV1024_TAP  9

`endif

/* tmr_pkg.sv */
// Types shared by the timer design files.
// Assumes the defines header supplies all numeric constants except the mode codes defined here.
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_WAVE_NORMAL = 2'b00,
    TMR_WAVE_PHASE  = 2'b01,
    TMR_WAVE_CLEAR  = 2'b10,
    TMR_WAVE_FAST   = 2'b11
  } tmr_wave_e;
  typedef enum logic [1:0] {
    TMR_OUT_OFF    = 2'b00,
    TMR_OUT_TOGGLE = 2'b01,
    TMR_OUT_CLEAR  = 2'b10,
    TMR_OUT_SET    = 2'b11
  } tmr_outmode_e;
endpackage

/* tmr_prescaler.sv */
// Prescaler that turns the system clock into a one-cycle timer tick.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module tmr_prescaler #(
  parameter int PRE_W = `TMR_PRE_W
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] clockSel,
  output logic            timerTick
);
  logic [PRE_W-1:0] div_q;
  logic [PRE_W-1:0] div_d;
  logic             tapHit;

  // The divider runs freely; a tap fires when its bit and all lower bits are ones.
  always_comb begin
    div_d = div_q + {{(PRE_W-1){1'b0}}, 1'b1};
    unique case (clockSel)
      3'h0:    tapHit = 1'b0;
      3'h1:    tapHit = 1'b1;
      3'h2:    tapHit = &div_q[`TMR_DIV8_TAP:0];
      3'h3:    tapHit = &div_q[`TMR_DIV32_TAP:0];
      3'h4:    tapHit = &div_q[`TMR_DIV64_TAP:0];
      3'h5:    tapHit = &div_q[`TMR_DIV128_TAP:0];
      3'h6:    tapHit = &div_q[`TMR_DIV256_TAP:0];
      default: tapHit = &div_q[`TMR_DIV1024_TAP:0];
    endcase
    timerTick = tapHit;
  end

  // Register the divider.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end
endmodule

/* test_timer8_control_compare.sv */
// Self-checking testbench for the 8-bit timer with one compare unit.
// Assumes the defines header and type package are compiled first; drives the register port directly.
`timescale 1ns/1ps
`include "tmr_defines.svh"

module test_timer8_control_compare;
  logic                   clk;
  logic                   sys_rst;
  logic [`TMR_ADDR_W-1:0] regAddr;
  logic [7:0]             regWdata;
  logic                   regWrite;
  logic                   regRead;
  logic [7:0]             regRdata;
  logic                   compareOutputPin;
  logic                   compareOutputOverride;
  logic                   overflowFlag;
  logic                   compareFlag;
  int                     failures;
  int                     num_checks;
  logic [7:0]             rdVal;
  logic                   pinExp;
  logic [7:0]             cmpVal;

  tmr_compare8 dut (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .regAddr               (regAddr),
    .regWdata              (regWdata),
    .regWrite              (regWrite),
    .regRead               (regRead),
    .regRdata              (regRdata),
    .compareOutputPin      (compareOutputPin),
    .compareOutputOverride (compareOutputOverride),
    .overflowFlag          (overflowFlag),
    .compareFlag           (compareFlag)
  );

  // ****************************************************************
  // Clock and watchdog.
  // ****************************************************************
  // Free-running 50 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The whole run needs well under 60000 cycles, so 100000 means a hang.
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  // Packs the control fields in their register positions.
  function automatic logic [7:0] ctl(input logic f, input logic [1:0] w, input logic [1:0] om,
                                     input logic [2:0] cs);
    return {f, w[0], om, w[1], cs};
  endfunction

  // Each register access task is entered just after a rising edge and leaves a gap cycle behind it.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
    @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic rng(input logic [15:0] got, input int lo, input int hi, input string msg);
    num_checks++;
    if ($isunknown(got) || !(int'(got) >= lo && int'(got) <= hi)) begin
      failures++;
      $display("unexpected at %0t: %s got %0d outside %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  // Counts high pin samples over two PWM periods and compares with the ideal duty.
  task automatic duty(input logic [1:0] w, input logic [1:0] om, input logic [7:0] c);
    int per;
    int hi;
    int ex;
    hi = 0;
    per = (w == tmr_pkg::TMR_WAVE_FAST) ? 512 : 1020;
    ex = (w == tmr_pkg::TMR_WAVE_FAST) ? 2 * (c + 1) : 4 * c;
    if (om == 2'b11) ex = per - ex;
    wr(`TMR_OFS_CTRL, 8'h00);
    wr(`TMR_OFS_CMP, c);
    wr(`TMR_OFS_CTRL, ctl(1'b0, w, om, 3'h1));
    // One full period first, so the buffered compare value has loaded at top.
    repeat (600) @(posedge clk);
    for (int i = 0; i < per; i++) begin
      @(posedge clk);
      #1 hi += (compareOutputPin === 1'b1);
    end
    rng(hi[15:0], ex - 8, ex + 8, "pwm duty");
    wr(`TMR_OFS_CTRL, 8'h00);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    failures = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    void'($urandom(32'h8ed7039a));
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset state of every register and of the pin and override outputs.
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], rdVal);
      chk(rdVal, 8'h00, "reset value");
    end
    chk({6'h0, compareOutputPin, compareOutputOverride}, 8'h00, "reset pins");
    $display("test reset done");
    // Every mode and output field reads back; the output takes over the pin when nonzero.
    for (int w = 0; w < 4; w++) begin
      for (int om = 0; om < 4; om++) begin
        wr(`TMR_OFS_CTRL, ctl(1'b0, w[1:0], om[1:0], 3'h0));
        rd(`TMR_OFS_CTRL, rdVal);
        chk(rdVal, ctl(1'b0, w[1:0], om[1:0], 3'h0), "control readback");
        chk({7'h0, compareOutputOverride}, {7'h0, om[1:0] != 2'b00}, "override");
      end
    end
    $display("test control done");
    // A stopped counter keeps any written value.
    cmpVal = 8'($urandom_range(0, 255));
    wr(`TMR_OFS_CTRL, 8'h00);
    wr(`TMR_OFS_COUNT, cmpVal);
    repeat (20) @(posedge clk);
    rd(`TMR_OFS_COUNT, rdVal);
    chk(rdVal, cmpVal, "stopped counter");
    $display("test stopped done");
    // Forced matches act per output mode in non-PWM modes only, without flag or clear.
    wr(`TMR_OFS_CMP, 8'h80);
    wr(`TMR_OFS_COUNT, 8'h10);
    pinExp = compareOutputPin;
    for (int om = 1; om < 4; om++) begin
      wr(`TMR_OFS_CTRL, ctl(1'b1, tmr_pkg::TMR_WAVE_NORMAL, om[1:0], 3'h0));
      pinExp = (om == 1) ? ~pinExp : (om == 3);
      repeat (2) @(posedge clk);
      chk({7'h0, compareOutputPin}, {7'h0, pinExp}, "forced pin");
      rd(`TMR_OFS_CTRL, rdVal);
      chk(rdVal[7:0], ctl(1'b0, tmr_pkg::TMR_WAVE_NORMAL, om[1:0], 3'h0), "strobe reads");
    end
    wr(`TMR_OFS_CTRL, ctl(1'b1, tmr_pkg::TMR_WAVE_CLEAR, 2'b01, 3'h0));
    pinExp = ~pinExp;
    repeat (2) @(posedge clk);
    chk({7'h0, compareOutputPin}, {7'h0, pinExp}, "forced toggle");
    rd(`TMR_OFS_COUNT, rdVal);
    chk(rdVal, 8'h10, "force no clear");
    chk({7'h0, compareFlag}, 8'h00, "force no flag");
    // In PWM the strobe is written as one on purpose: it must be ignored.
    wr(`TMR_OFS_CTRL, ctl(1'b1, tmr_pkg::TMR_WAVE_FAST, 2'b01, 3'h0));
    repeat (2) @(posedge clk);
    chk({7'h0, compareOutputPin}, {7'h0, pinExp}, "force in pwm");
    $display("test force done");
    // Normal mode wraps past MAX with a toggle on the way.
    wr(`TMR_OFS_CTRL, 8'h00);
    wr(`TMR_OFS_COUNT, 8'hFC);
    wr(`TMR_OFS_CMP, 8'hFE);
    wr(`TMR_OFS_STAT, 8'h03);
    pinExp = ~compareOutputPin;
    wr(`TMR_OFS_CTRL, ctl(1'b0, tmr_pkg::TMR_WAVE_NORMAL, 2'b01, 3'h1));
    for (int i = 0; i < 20 && overflowFlag !== 1'b1; i++) @(posedge clk);
    wr(`TMR_OFS_CTRL, 8'h00);
    rd(`TMR_OFS_STAT, rdVal);
    chk(rdVal, 8'h03, "overflow and match");
    chk({7'h0, overflowFlag}, 8'h01, "overflow output");
    chk({7'h0, compareOutputPin}, {7'h0, pinExp}, "match toggle");
    rd(`TMR_OFS_COUNT, rdVal);
    rng({8'h0, rdVal}, 0, 8, "wrapped count");
    wr(`TMR_OFS_STAT, 8'h03);
    rd(`TMR_OFS_STAT, rdVal);
    chk(rdVal, 8'h00, "status cleared");
    $display("test overflow done");
    // A counter write onto the compare value suppresses that match.
    wr(`TMR_OFS_CMP, 8'h40);
    wr(`TMR_OFS_CTRL, ctl(1'b0, tmr_pkg::TMR_WAVE_NORMAL, 2'b00, 3'h1));
    wr(`TMR_OFS_COUNT, 8'h40);
    repeat (10) @(posedge clk);
    chk({7'h0, compareFlag}, 8'h00, "blocked match");
    $display("test blocked done");
    // Clear-on-match keeps the count at or below the compare value.
    wr(`TMR_OFS_CTRL, 8'h00);
    wr(`TMR_OFS_CMP, 8'h03);
    wr(`TMR_OFS_COUNT, 8'h00);
    wr(`TMR_OFS_CTRL, ctl(1'b0, tmr_pkg::TMR_WAVE_CLEAR, 2'b00, 3'h1));
    for (int i = 0; i < 8; i++) begin
      repeat ($urandom_range(1, 20)) @(posedge clk);
      rd(`TMR_OFS_COUNT, rdVal);
      rng({8'h0, rdVal}, 0, 3, "clear on match top");
    end
    $display("test ctc done");
    // Each prescale setting gives about four ticks in four divider periods.
    for (int cs = 1; cs < 8; cs++) begin
      int n;
      n = (cs == 1) ? 1 : (cs == 2) ? 8 : (32 << (cs - 3));
      if (cs == 7) n = 1024;
      wr(`TMR_OFS_CTRL, 8'h00);
      wr(`TMR_OFS_COUNT, 8'h00);
      wr(`TMR_OFS_CTRL, ctl(1'b0, tmr_pkg::TMR_WAVE_NORMAL, 2'b00, cs[2:0]));
      repeat (4 * n - 2) @(posedge clk);
      wr(`TMR_OFS_CTRL, 8'h00);
      rd(`TMR_OFS_COUNT, rdVal);
      rng({8'h0, rdVal}, 3, 5, "prescaled count");
    end
    $display("test prescale done");
    // PWM duty in both slopes and polarities, extremes and a random value.
    for (int w = 0; w < 2; w++) begin
      for (int om = 2; om < 4; om++) begin
        duty(w ? tmr_pkg::TMR_WAVE_FAST : tmr_pkg::TMR_WAVE_PHASE, om[1:0], 8'h00);
        duty(w ? tmr_pkg::TMR_WAVE_FAST : tmr_pkg::TMR_WAVE_PHASE, om[1:0], 8'hFF);
        duty(w ? tmr_pkg::TMR_WAVE_FAST : tmr_pkg::TMR_WAVE_PHASE, om[1:0],
             8'($urandom_range(16, 239)));
      end
    end
    $display("test pwm done");
    tally_and_finish();
  end
endmodule
